// ===== timer2_capture_reload.v
// Capture/reload timer with baud generator and clock-out, APB slave.
// Assumes a zero-wait APB master; trigger and count pins are asynchronous;
// timer1Overflow and irqEnable come from logic on the same clock.
`timescale 1ns/1ps
`include "timer2_defs.vh"
`default_nettype none

module timer2_capture_reload
#(
  parameter ADDR_WIDTH = 12
)
(
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire triggerPin,
  input wire countInputPin,
  input wire speedSelect,
  input wire timer1Overflow,
  input wire irqEnable,
  output wire timerIrq,
  output wire rxBaudTick,
  output wire txBaudTick,
  output wire clockOut,
  output wire clockOutEnable,
  output wire [3:0] intFlagAutoclear
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg [7:0] control_reg;
  reg [7:0] control_next;
  reg [7:0] mode_reg;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg [15:0] capture_reg;
  reg [15:0] capture_next;
  reg [7:0] prescale_reg;
  reg [7:0] prescale_next;
  reg baudPhase_reg;
  reg [31:0] prdata_reg;
  reg irq_reg;
  reg rxTick_reg;
  reg txTick_reg;
  reg clockOut_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire [7:0] regIndex;
  wire setupPhase;
  wire accessPhase;
  wire hit;
  wire wrEn;
  wire wrLane;
  wire [7:0] wrByte;

  function selIdx;
    input [7:0] idx;
    input [7:0] target;
    begin
      selIdx = (idx == target);
    end
  endfunction

  assign regIndex = paddr[9:2];
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign hit = (paddr[ADDR_WIDTH-1:10] == {(ADDR_WIDTH-10){1'b0}})
    & (regIndex >= `IDX_CONTROL) & (regIndex <= `IDX_COUNT_HIGH);
  // Registers are one byte wide, so only lane 0 matters
  assign wrLane = pstrb[0];
  assign wrEn = accessPhase & pwrite & hit & wrLane;
  assign wrByte = pwdata[7:0];

  wire wrControl;
  wire wrMode;
  wire wrCapLow;
  wire wrCapHigh;
  wire wrCountLow;
  wire wrCountHigh;

  assign wrControl = wrEn & selIdx(regIndex, `IDX_CONTROL);
  assign wrMode = wrEn & selIdx(regIndex, `IDX_MODE);
  assign wrCapLow = wrEn & selIdx(regIndex, `IDX_CAP_LOW);
  assign wrCapHigh = wrEn & selIdx(regIndex, `IDX_CAP_HIGH);
  assign wrCountLow = wrEn & selIdx(regIndex, `IDX_COUNT_LOW);
  assign wrCountHigh = wrEn & selIdx(regIndex, `IDX_COUNT_HIGH);

  assign pready = 1'b1;
  assign pslverr = accessPhase & ~hit;
  assign prdata = prdata_reg;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire trigLevel;
  wire trigFall;
  wire countFall;

  pin_sync triggerSync
  (
    .clk(clk),
    .resetn(resetn),
    .pinIn(triggerPin),
    .level(trigLevel),
    .fall(trigFall)
  );

  pin_sync countSync
  (
    .clk(clk),
    .resetn(resetn),
    .pinIn(countInputPin),
    .level(),
    .fall(countFall)
  );

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  wire rxSel;
  wire txSel;
  wire baudMode;
  wire pinEnable;
  wire runOn;
  wire counterSel;
  wire captureSel;
  wire downEnable;
  wire captureClear;
  wire [7:0] preDiv;
  wire preTick;
  wire tick;
  wire trigEdge;

  assign rxSel = control_reg[`CTL_RX_BAUD];
  assign txSel = control_reg[`CTL_TX_BAUD];
  assign baudMode = rxSel | txSel;
  assign pinEnable = control_reg[`CTL_PIN_EN];
  assign runOn = control_reg[`CTL_RUN];
  assign counterSel = control_reg[`CTL_COUNTER_SEL];
  assign captureSel = control_reg[`CTL_CAP_SEL];
  assign downEnable = mode_reg[`MOD_DOWN_EN];
  assign captureClear = mode_reg[`MOD_CAP_CLEAR];
  assign preDiv = speedSelect ? `PRE_DIV_FAST : `PRE_DIV_SLOW;
  assign preTick = (prescale_reg == preDiv - `PRE_ONE);
  // Tick source: baud phase overrides the counter select bit
  assign tick = runOn & (baudMode ? baudPhase_reg
    : (counterSel ? countFall : preTick));
  assign trigEdge = trigFall & pinEnable;

  // ------------------------------------------------------------
  // Counter, capture and flag next state
  // ------------------------------------------------------------
  reg overflowSet;
  reg externalSet;
  reg overflowPulse;

  always @*
  begin
    count_next = count_reg;
    capture_next = capture_reg;
    overflowSet = 1'b0;
    externalSet = 1'b0;
    overflowPulse = 1'b0;
    if (baudMode)
    begin
      // Capture select is ignored; every overflow reloads
      if (tick)
      begin
        if (count_reg == `COUNT_MAX)
        begin
          count_next = capture_reg;
          overflowPulse = 1'b1;
        end
        else
          count_next = count_reg + 16'h0001;
      end
      // The pin only raises the flag here, no capture or reload
      if (trigEdge)
        externalSet = 1'b1;
    end
    else if (captureSel)
    begin
      if (tick)
      begin
        if (count_reg == `COUNT_MAX)
        begin
          count_next = `RST_COUNT;
          overflowSet = 1'b1;
          overflowPulse = 1'b1;
        end
        else
          count_next = count_reg + 16'h0001;
      end
      if (trigEdge)
      begin
        capture_next = count_reg;
        externalSet = 1'b1;
        if (captureClear)
          count_next = `RST_COUNT;
      end
    end
    else if (downEnable)
    begin
      // Pin level steers direction instead of triggering reloads
      if (tick)
      begin
        if (trigLevel)
        begin
          if (count_reg == `COUNT_MAX)
          begin
            count_next = capture_reg;
            overflowSet = 1'b1;
            externalSet = 1'b1;
            overflowPulse = 1'b1;
          end
          else
            count_next = count_reg + 16'h0001;
        end
        else
        begin
          if (count_reg == capture_reg)
          begin
            count_next = `COUNT_MAX;
            overflowSet = 1'b1;
            externalSet = 1'b1;
            overflowPulse = 1'b1;
          end
          else
            count_next = count_reg - 16'h0001;
        end
      end
    end
    else
    begin
      if (tick)
      begin
        if (count_reg == `COUNT_MAX)
        begin
          count_next = capture_reg;
          overflowSet = 1'b1;
          overflowPulse = 1'b1;
        end
        else
          count_next = count_reg + 16'h0001;
      end
      if (trigEdge)
      begin
        count_next = capture_reg;
        externalSet = 1'b1;
      end
    end
    // Software writes to data bytes win over hardware updates
    if (wrCountLow)
      count_next[7:0] = wrByte;
    if (wrCountHigh)
      count_next[15:8] = wrByte;
    if (wrCapLow)
      capture_next[7:0] = wrByte;
    if (wrCapHigh)
      capture_next[15:8] = wrByte;
  end

  // Hardware set wins over a software clear in the same cycle
  always @*
  begin
    control_next = wrControl ? wrByte : control_reg;
    if (overflowSet & ~baudMode)
      control_next[`CTL_OVERFLOW] = 1'b1;
    if (externalSet)
      control_next[`CTL_EXTERNAL] = 1'b1;
  end

  always @*
  begin
    if (baudMode | ~runOn | preTick)
      prescale_next = `RST_BYTE;
    else
      prescale_next = prescale_reg + `PRE_ONE;
  end

  // ------------------------------------------------------------
  // Read data, captured in the setup phase
  // ------------------------------------------------------------
  reg [7:0] readByte;

  always @*
  begin
    readByte = `RST_BYTE;
    case (regIndex)
      `IDX_CONTROL: readByte = control_reg;
      `IDX_MODE: readByte = mode_reg;
      `IDX_CAP_LOW: readByte = capture_reg[7:0];
      `IDX_CAP_HIGH: readByte = capture_reg[15:8];
      `IDX_COUNT_LOW: readByte = count_reg[7:0];
      `IDX_COUNT_HIGH: readByte = count_reg[15:8];
      default: readByte = `RST_BYTE;
    endcase
  end

  // ------------------------------------------------------------
  // Sequential state
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      control_reg <= `RST_BYTE;
      mode_reg <= `RST_BYTE;
      count_reg <= `RST_COUNT;
      capture_reg <= `RST_COUNT;
      prescale_reg <= `RST_BYTE;
      baudPhase_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      control_reg <= control_next;
      if (wrMode)
        mode_reg <= wrByte & `MOD_WRITE_MASK;
      count_reg <= count_next;
      capture_reg <= capture_next;
      prescale_reg <= prescale_next;
      baudPhase_reg <= baudMode & ~baudPhase_reg;
      if (setupPhase)
        prdata_reg <= {24'h000000, hit ? readByte : `RST_BYTE};
    end
  end

  // ------------------------------------------------------------
  // Interrupt, baud and clock-out outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_reg <= 1'b0;
      rxTick_reg <= 1'b0;
      txTick_reg <= 1'b0;
      clockOut_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irqEnable & (control_next[`CTL_EXTERNAL]
        | control_next[`CTL_OVERFLOW]);
      rxTick_reg <= rxSel ? overflowPulse : timer1Overflow;
      txTick_reg <= txSel ? overflowPulse : timer1Overflow;
      // Toggles per overflow, so output period is two overflows
      if (!mode_reg[`MOD_CLK_OUT])
        clockOut_reg <= 1'b0;
      else if (overflowPulse)
        clockOut_reg <= ~clockOut_reg;
    end
  end

  assign timerIrq = irq_reg;
  assign rxBaudTick = rxTick_reg;
  assign txBaudTick = txTick_reg;
  assign clockOut = clockOut_reg;
  assign clockOutEnable = mode_reg[`MOD_CLK_OUT];
  // Flags of external ints 5..2 live elsewhere; only the enables go out
  assign intFlagAutoclear =
    mode_reg[`MOD_AUTOCLR_HI:`MOD_AUTOCLR_LO];

endmodule // timer2_capture_reload

`default_nettype wire

// ===== timer2_defs.vh
// Constants for the capture/reload timer and its APB register window.
// Assumes an APB master with 32-bit data and byte addressing.
`ifndef TIMER2_DEFS_VH
`define TIMER2_DEFS_VH

// --------------------------------------------------------------
// Register indices; byte address is four times the index
// --------------------------------------------------------------
`define IDX_CONTROL 8'hc8
`define IDX_MODE 8'hc9
`define IDX_CAP_LOW 8'hca
`define IDX_CAP_HIGH 8'hcb
`define IDX_COUNT_LOW 8'hcc
`define IDX_COUNT_HIGH 8'hcd

// --------------------------------------------------------------
// Control register bit positions
// --------------------------------------------------------------
`define CTL_OVERFLOW 7
`define CTL_EXTERNAL 6
`define CTL_RX_BAUD 5
`define CTL_TX_BAUD 4
`define CTL_PIN_EN 3
`define CTL_RUN 2
`define CTL_COUNTER_SEL 1
`define CTL_CAP_SEL 0

// --------------------------------------------------------------
// Mode register bit positions
// --------------------------------------------------------------
`define MOD_AUTOCLR_HI 7
`define MOD_AUTOCLR_LO 4
`define MOD_CAP_CLEAR 3
`define MOD_CLK_OUT 1
`define MOD_DOWN_EN 0
`define MOD_WRITE_MASK 8'hfb

// --------------------------------------------------------------
// Reset values and counter limits
// --------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define COUNT_MAX 16'hffff
`define PRE_DIV_SLOW 8'h0c
`define PRE_DIV_FAST 8'h04
`define PRE_ONE 8'h01

`endif

// ===== pin_sync.v
// Three-stage synchroniser with a stable level and falling-edge pulse.
// Assumes an asynchronous pin that idles high.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
  input wire clk,
  input wire resetn,
  input wire pinIn,
  output wire level,
  output wire fall
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;
  reg level_reg;
  reg fall_reg;
  wire agree;

  // A change counts only once the last two stages agree
  assign agree = (stage2_reg == stage3_reg);
  assign level = level_reg;
  assign fall = fall_reg;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
      stage3_reg <= 1'b1;
      level_reg <= 1'b1;
      fall_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (agree)
        level_reg <= stage3_reg;
      fall_reg <= agree & level_reg & ~stage3_reg;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ===== timer2_capture_reload_chk.sv
// Port-level assertions for the capture/reload timer.
// Assumes it is bound onto every timer2_capture_reload instance.
`timescale 1ns/1ps
`include "timer2_defs.vh"
`default_nettype none
module timer2_capture_reload_chk
#(
  parameter ADDR_WIDTH = 12
)
(
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irqEnable,
  input wire timerIrq,
  input wire rxBaudTick,
  input wire txBaudTick,
  input wire clockOut,
  input wire clockOutEnable,
  input wire [3:0] intFlagAutoclear
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_modeWrite;
    psel && penable && pwrite && pstrb[0] && paddr == {2'b00, `IDX_MODE, 2'b00};
  endsequence
  sequence s_badSetup;
    psel && !penable && !pwrite && paddr[ADDR_WIDTH-1:10] != 0;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_autoclear;
    s_modeWrite |=> intFlagAutoclear == $past(pwdata[7:4]);
  endproperty
  property p_clkEnable;
    s_modeWrite |=> clockOutEnable == $past(pwdata[1]);
  endproperty
  property p_clkOff;
    !clockOutEnable && $past(!clockOutEnable) |-> !clockOut;
  endproperty
  property p_irqOff;
    !irqEnable && $past(!irqEnable) |-> !timerIrq;
  endproperty
  property p_rxPulse;
    rxBaudTick |=> !rxBaudTick;
  endproperty
  property p_txPulse;
    txBaudTick |=> !txBaudTick;
  endproperty
  property p_badRead;
    s_badSetup ##1 penable |-> prdata == 32'h0 && pslverr;
  endproperty
  property p_upper;
    prdata[31:8] == 24'h0;
  endproperty
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_autoclear: assert property (p_autoclear)
    else $error("autoclear bits differ from mode write");
  a_clkEnable: assert property (p_clkEnable)
    else $error("clock-out enable differs from mode write");
  a_clkOff: assert property (p_clkOff)
    else $error("clock output active while disabled");
  a_irqOff: assert property (p_irqOff)
    else $error("interrupt raised while disabled");
  a_rxPulse: assert property (p_rxPulse)
    else $error("receive tick wider than one cycle");
  a_txPulse: assert property (p_txPulse)
    else $error("transmit tick wider than one cycle");
  a_badRead: assert property (p_badRead)
    else $error("unmapped read not refused");
  a_upper: assert property (p_upper)
    else $error("read data upper bits not zero");
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
endmodule // timer2_capture_reload_chk
bind timer2_capture_reload timer2_capture_reload_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk
(
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqEnable(irqEnable), .timerIrq(timerIrq), .rxBaudTick(rxBaudTick),
  .txBaudTick(txBaudTick), .clockOut(clockOut),
  .clockOutEnable(clockOutEnable), .intFlagAutoclear(intFlagAutoclear)
);
`default_nettype wire

// ===== pin_driver_model.sv
// Model of the trigger and count pins that face the timer.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pin_driver_model
(
  input wire logic clk,
  output logic triggerPin,
  output logic countInputPin
);
  // Pins idle high, matching the synchroniser reset level
  initial triggerPin = 1'b1;
  initial countInputPin = 1'b1;
  // Six clocks per level, well beyond the three-flop sync
  task hold6;
    repeat (6) @(posedge clk);
  endtask
  task fallTrigger;
    triggerPin <= 1'b0;
    hold6;
    triggerPin <= 1'b1;
    hold6;
  endtask
  task setTrigger(input logic v);
    triggerPin <= v;
    hold6;
  endtask
  task pulseCount;
    countInputPin <= 1'b0;
    hold6;
    countInputPin <= 1'b1;
    hold6;
  endtask
endmodule // pin_driver_model
`default_nettype wire

// ===== timer2_capture_reload_tb_top.sv
// Self-checking bench for the capture/reload timer.
// Assumes pin_driver_model drives the trigger and count pins.
`timescale 1ns/1ps
`include "timer2_defs.vh"
`default_nettype none
module timer2_capture_reload_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic speedSelect = 1'b1;
  logic timer1Overflow = 1'b0;
  logic irqEnable = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, triggerPin, countInputPin, timerIrq;
  wire rxBaudTick, txBaudTick, clockOut, clockOutEnable;
  wire [3:0] intFlagAutoclear;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int nr, nt, nc;
  logic [7:0] rd;
  logic er;
  logic last;
  always #2 clk = ~clk;
  pin_driver_model pins (.clk(clk), .triggerPin(triggerPin),
    .countInputPin(countInputPin));
  timer2_capture_reload dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .triggerPin(triggerPin), .countInputPin(countInputPin),
    .speedSelect(speedSelect), .timer1Overflow(timer1Overflow),
    .irqEnable(irqEnable), .timerIrq(timerIrq), .rxBaudTick(rxBaudTick),
    .txBaudTick(txBaudTick), .clockOut(clockOut),
    .clockOutEnable(clockOutEnable), .intFlagAutoclear(intFlagAutoclear));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // A hang costs one mismatch and ends the run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      test_done;
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= {3'b000, s};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d, 1'b1);
  endtask
  task rdc(input logic [7:0] i, input logic [7:0] exp, input string what);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h00, 1'b1);
    chk(what, {8'h00, exp}, {8'h00, rd});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    logic [7:0] i;
    for (i = `IDX_CONTROL; i <= `IDX_COUNT_HIGH; i++)
      rdc(i, `RST_BYTE, "reset value");
    wr(`IDX_MODE, 8'hff);
    rdc(`IDX_MODE, `MOD_WRITE_MASK, "timer2_mode_control");
    chk("autoclear", 16'h000f, {12'h000, intFlagAutoclear});
    chk("clock out enable", 16'h0001, {15'h0, clockOutEnable});
    apb(1'b1, {2'b00, `IDX_MODE, 2'b00}, 8'h00, 1'b0);
    rdc(`IDX_MODE, `MOD_WRITE_MASK, "strobe-less write");
    apb(1'b1, 12'hf20, 8'h00, 1'b1);
    chk("unmapped error", 16'h0001, {15'h0, er});
    apb(1'b0, 12'hf20, 8'h00, 1'b1);
    chk("unmapped read data", 16'h0000, {8'h00, rd});
    chk("unmapped read error", 16'h0001, {15'h0, er});
    wr(`IDX_MODE, 8'h00);
    $display("register test done");
  endtask
  task t_capture;
    irqEnable <= 1'b1;
    wr(`IDX_MODE, 8'h08);
    wr(`IDX_COUNT_LOW, 8'h34);
    wr(`IDX_COUNT_HIGH, 8'h12);
    wr(`IDX_CONTROL, 8'h0f);
    pins.fallTrigger();
    rdc(`IDX_CAP_LOW, 8'h34, "timer2_capture_low");
    rdc(`IDX_CAP_HIGH, 8'h12, "timer2_capture_high");
    rdc(`IDX_COUNT_LOW, 8'h00, "timer2_count_low");
    rdc(`IDX_COUNT_HIGH, 8'h00, "timer2_count_high");
    rdc(`IDX_CONTROL, 8'h4f, "timer2_control");
    chk("timerIrq", 16'h0001, {15'h0, timerIrq});
    wr(`IDX_CONTROL, 8'h07);
    wr(`IDX_COUNT_LOW, 8'h55);
    pins.fallTrigger();
    rdc(`IDX_CAP_LOW, 8'h34, "ignored capture");
    rdc(`IDX_CONTROL, 8'h07, "ignored flag");
    chk("timerIrq", 16'h0000, {15'h0, timerIrq});
    irqEnable <= 1'b0;
    wr(`IDX_MODE, 8'h00);
    $display("capture test done");
  endtask
  task t_reload;
    wr(`IDX_CONTROL, 8'h00);
    wr(`IDX_CAP_LOW, 8'hcd);
    wr(`IDX_CAP_HIGH, 8'hab);
    wr(`IDX_COUNT_LOW, 8'hfd);
    wr(`IDX_COUNT_HIGH, 8'hff);
    wr(`IDX_CONTROL, 8'h06);
    pins.pulseCount();
    rdc(`IDX_COUNT_LOW, 8'hfe, "count edge");
    wr(`IDX_CONTROL, 8'h02);
    pins.pulseCount();
    rdc(`IDX_COUNT_LOW, 8'hfe, "stopped count");
    wr(`IDX_CONTROL, 8'h06);
    pins.pulseCount();
    pins.pulseCount();
    rdc(`IDX_COUNT_LOW, 8'hcd, "reload low");
    rdc(`IDX_COUNT_HIGH, 8'hab, "reload high");
    rdc(`IDX_CONTROL, 8'h86, "overflow flag");
    wr(`IDX_CONTROL, 8'h06);
    rdc(`IDX_CONTROL, 8'h06, "software clear");
    wr(`IDX_CONTROL, 8'hc0);
    rdc(`IDX_CONTROL, 8'hc0, "software set");
    wr(`IDX_CONTROL, 8'h00);
    $display("reload test done");
  endtask
  task t_down;
    wr(`IDX_MODE, 8'h01);
    wr(`IDX_COUNT_LOW, 8'h05);
    wr(`IDX_COUNT_HIGH, 8'h00);
    wr(`IDX_CONTROL, 8'h06);
    pins.pulseCount();
    rdc(`IDX_COUNT_LOW, 8'h06, "count up");
    pins.setTrigger(1'b0);
    pins.pulseCount();
    rdc(`IDX_COUNT_LOW, 8'h05, "count down");
    // Reload value equal to the count: the next down tick is a match
    wr(`IDX_CAP_LOW, 8'h05);
    wr(`IDX_CAP_HIGH, 8'h00);
    pins.pulseCount();
    rdc(`IDX_COUNT_HIGH, 8'hff, "down match load");
    rdc(`IDX_CONTROL, 8'hc6, "down match flags");
    pins.setTrigger(1'b1);
    wr(`IDX_CONTROL, 8'h00);
    wr(`IDX_MODE, 8'h00);
    $display("down-count test done");
  endtask
  // Run stays on for 43 clocks after the enabling write
  task t_timer;
    wr(`IDX_COUNT_LOW, 8'h00);
    wr(`IDX_COUNT_HIGH, 8'h00);
    wr(`IDX_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    wr(`IDX_CONTROL, 8'h00);
    rdc(`IDX_COUNT_LOW, 8'h0a, "fast timer count");
    speedSelect <= 1'b0;
    wr(`IDX_COUNT_LOW, 8'h00);
    wr(`IDX_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    wr(`IDX_CONTROL, 8'h00);
    rdc(`IDX_COUNT_LOW, 8'h03, "slow timer count");
    speedSelect <= 1'b1;
    $display("timer test done");
  endtask
  task t_baud;
    wr(`IDX_MODE, 8'h02);
    wr(`IDX_CAP_LOW, 8'hfe);
    wr(`IDX_CAP_HIGH, 8'hff);
    wr(`IDX_COUNT_LOW, 8'hfe);
    wr(`IDX_COUNT_HIGH, 8'hff);
    wr(`IDX_CONTROL, 8'h35);
    nr = 0;
    nt = 0;
    nc = 0;
    last = clockOut;
    // Reload of fffe overflows every two ticks, so every four clocks
    repeat (400) @(negedge clk)
    begin
      nr += (rxBaudTick === 1'b1);
      nt += (txBaudTick === 1'b1);
      nc += (clockOut !== last);
      last = clockOut;
    end
    chk("rx ticks", 16'h0001, {15'h0, nr >= 99 && nr <= 101});
    chk("tx ticks", 16'h0001, {15'h0, nt >= 99 && nt <= 101});
    chk("clock out", 16'h0001, {15'h0, nc >= 99 && nc <= 101});
    rdc(`IDX_CONTROL, 8'h35, "baud flags");
    wr(`IDX_CONTROL, 8'h00);
    nr = 0;
    nt = 0;
    repeat (5)
    begin
      timer1Overflow <= 1'b1;
      @(posedge clk);
      timer1Overflow <= 1'b0;
      repeat (4) @(negedge clk)
      begin
        nr += (rxBaudTick === 1'b1);
        nt += (txBaudTick === 1'b1);
      end
      @(posedge clk);
    end
    chk("rx timer1 ticks", 16'h0005, nr[15:0]);
    chk("tx timer1 ticks", 16'h0005, nt[15:0]);
    wr(`IDX_MODE, 8'h00);
    $display("baud test done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_capture;
    t_reload;
    t_down;
    t_timer;
    t_baud;
    test_done;
  end
endmodule // timer2_capture_reload_tb_top
`default_nettype wire
